// ===== design/mcsr_pkg.sv
package mcsr_pkg;
    // register addresses on the device's internal register port
    localparam logic [7:0] MCSR_ADDR_CONFIG = 8'h40;
    localparam logic [7:0] MCSR_ADDR_STAT1  = 8'h41;

    // configuration bit positions
    localparam int MCSR_CFG_GO       = 0;
    localparam int MCSR_CFG_LOCK     = 1;
    localparam int MCSR_CFG_READY    = 2;
    localparam int MCSR_CFG_FANS_MAX = 3;
    localparam int MCSR_CFG_SPIN     = 5;
    localparam int MCSR_CFG_TMO_OFF  = 6;
    localparam int MCSR_CFG_VSCALE   = 7;

    // first status bit positions
    localparam int MCSR_ST_MID  = 0;
    localparam int MCSR_ST_VCC  = 2;
    localparam int MCSR_ST_R1T  = 4;
    localparam int MCSR_ST_LT   = 5;
    localparam int MCSR_ST_R2T  = 6;
    localparam int MCSR_ST_SUM  = 7;

    // reserved bit positions, always read as zero
    localparam int MCSR_CFG_RSVD  = 4;
    localparam int MCSR_ST_RSVD_A = 1;
    localparam int MCSR_ST_RSVD_B = 3;

    localparam logic [7:0] MCSR_CFG_RESET  = 8'h00;
    localparam logic [7:0] MCSR_STAT_RESET = 8'h00;
    localparam logic [7:0] MCSR_RD_UNMAPPED = 8'h00;

    // latched flags in status order: mid rail, vcc, remote 1, local, remote 2
    localparam int MCSR_NFLAGS = 5;

    // power-up settle time before ready, in microseconds
    localparam int MCSR_PWRUP_US     = 10;
    localparam int MCSR_CLK_MHZ      = 50;
    localparam int MCSR_PWRUP_CYCLES = MCSR_PWRUP_US * MCSR_CLK_MHZ;

    // register port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mcsr_req_t;

    // live out-of-limit conditions from the measurement logic
    typedef struct packed {
        logic remote_two_temp;
        logic local_temp;
        logic remote_one_temp;
        logic vcc_volt;
        logic mid_rail_volt;
    } mcsr_cond_t;

    // controls handed to monitoring and fan logic
    typedef struct packed {
        logic monitor_go;
        logic all_fans_max;
        logic spinup_tach_skip;
        logic bus_timeout_off;
        logic vcc_five_volt;
        logic lock;
    } mcsr_ctrl_t;
endpackage

// ===== design/mcsr_regs.sv
// How it works
// - go bit set: monitor using programmed limits
// - go clear: default limits, programmed limits kept
// - lock makes go bit read-only
// - lock is write-once; lockable bits freeze
// - ready bit rises after power-up completes
// - fans-max bit forces full speed, never locks
// - config bit 4, status bits 1,3 reserved
// - spin-up skip holds PWM high whole timeout
// - lockable bit 6 disables bus timeout
// - lockable bit 7 picks 5 V or 3.3 V scaling
// - status bits 0,2 flag voltage limits
// - status bits 4,5,6 flag temperature limits
// - read clears flag only if condition ended
// - status bit 7 is OR of second status
module mcsr_regs
    import mcsr_pkg::*;
#(
    parameter int PWRUP_CYCLES = MCSR_PWRUP_CYCLES
) (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // register port
    input  wire mcsr_req_t  req,
    output logic [7:0]      rdata_q,
    // event sources
    input  wire mcsr_cond_t cond,
    input  wire logic [7:0] status_two,
    // controls
    output mcsr_ctrl_t      ctrl
);
    // a zero settle time would leave the counter with no bits
    if (PWRUP_CYCLES < 1) begin : g_bad_cycles
        $error("PWRUP_CYCLES must be at least 1");
    end

    localparam int CNT_W       = $clog2(PWRUP_CYCLES + 1);
    // ready must follow release within the settle time plus pipeline slack
    localparam int READY_LIMIT = PWRUP_CYCLES + 2;

    function automatic logic hit(input mcsr_req_t r, input logic [7:0] a);
        return r.addr == a;
    endfunction

    logic       go_q, lock_q, max_q, spin_q, tmo_q, vsc_q, ready_q;
    logic [MCSR_NFLAGS-1:0] flag_q;
    logic [CNT_W-1:0]       pwr_cnt_q;
    logic [7:0] cfg_view, st_view;
    logic       cfg_wr, st_rd;

    assign cfg_wr = req.wr && hit(req, MCSR_ADDR_CONFIG);
    assign st_rd  = req.rd && hit(req, MCSR_ADDR_STAT1);

    // lockable bits only take writes while unlocked
    always_ff @(posedge core_clk) begin
        if (rst) begin
            go_q   <= 1'b0;
            lock_q <= 1'b0;
            spin_q <= 1'b0;
            tmo_q  <= 1'b0;
            vsc_q  <= 1'b0;
        end else if (cfg_wr && !lock_q) begin
            go_q   <= req.wdata[MCSR_CFG_GO];
            lock_q <= req.wdata[MCSR_CFG_LOCK];
            spin_q <= req.wdata[MCSR_CFG_SPIN];
            tmo_q  <= req.wdata[MCSR_CFG_TMO_OFF];
            vsc_q  <= req.wdata[MCSR_CFG_VSCALE];
        end
    end

    // fans-max stays writable regardless of lock
    always_ff @(posedge core_clk) begin
        if (rst) begin
            max_q <= 1'b0;
        end else if (cfg_wr) begin
            max_q <= req.wdata[MCSR_CFG_FANS_MAX];
        end
    end

    // power-up settle counter for ready
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pwr_cnt_q <= '0;
            ready_q   <= 1'b0;
        end else if (!ready_q) begin
            if (pwr_cnt_q == CNT_W'(PWRUP_CYCLES - 1)) begin
                ready_q <= 1'b1;
            end
            pwr_cnt_q <= pwr_cnt_q + 1'b1;
        end
    end

    // sticky flags: a live condition always wins over the read clear
    for (genvar i = 0; i < MCSR_NFLAGS; i++) begin : g_flag
        always_ff @(posedge core_clk) begin
            if (rst) begin
                flag_q[i] <= 1'b0;
            end else if (cond[i]) begin
                flag_q[i] <= 1'b1;
            end else if (st_rd) begin
                flag_q[i] <= 1'b0;
            end
        end
    end

    always_comb begin
        cfg_view = MCSR_CFG_RESET;
        cfg_view[MCSR_CFG_GO]       = go_q;
        cfg_view[MCSR_CFG_LOCK]     = lock_q;
        cfg_view[MCSR_CFG_READY]    = ready_q;
        cfg_view[MCSR_CFG_FANS_MAX] = max_q;
        cfg_view[MCSR_CFG_SPIN]     = spin_q;
        cfg_view[MCSR_CFG_TMO_OFF]  = tmo_q;
        cfg_view[MCSR_CFG_VSCALE]   = vsc_q;
        st_view = MCSR_STAT_RESET;
        st_view[MCSR_ST_MID] = flag_q[0];
        st_view[MCSR_ST_VCC] = flag_q[1];
        st_view[MCSR_ST_R1T] = flag_q[2];
        st_view[MCSR_ST_LT]  = flag_q[3];
        st_view[MCSR_ST_R2T] = flag_q[4];
        st_view[MCSR_ST_SUM] = |status_two;
    end

    // read data registered one cycle after the read strobe
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_q <= MCSR_RD_UNMAPPED;
        end else if (req.rd) begin
            if (hit(req, MCSR_ADDR_CONFIG)) begin
                rdata_q <= cfg_view;
            end else if (hit(req, MCSR_ADDR_STAT1)) begin
                rdata_q <= st_view;
            end else begin
                rdata_q <= MCSR_RD_UNMAPPED;
            end
        end
    end

    // limit selection itself lives in the monitor; go only picks the set
    assign ctrl.monitor_go       = go_q;
    assign ctrl.all_fans_max     = max_q;
    assign ctrl.spinup_tach_skip = spin_q;
    assign ctrl.bus_timeout_off  = tmo_q;
    assign ctrl.vcc_five_volt    = vsc_q;
    assign ctrl.lock             = lock_q;

    // lock, fans-max, ready, flag, summary and reserved-bit behaviour
    a_lock_holds_go: assert property (@(posedge core_clk) disable iff (rst)
        lock_q |=> (go_q == $past(go_q)))
        else $error("go bit changed while locked");
    a_lock_sticky: assert property (@(posedge core_clk) disable iff (rst)
        lock_q |=> lock_q)
        else $error("lock cleared without reset");
    a_locked_cfg_frozen: assert property (@(posedge core_clk) disable iff (rst)
        lock_q |=> $stable({tmo_q, vsc_q, spin_q}))
        else $error("locked bit changed");
    a_fans_max_write: assert property (@(posedge core_clk) disable iff (rst)
        cfg_wr |=> (max_q == $past(req.wdata[MCSR_CFG_FANS_MAX])))
        else $error("fans max write lost");
    a_ready_rises: assert property (@(posedge core_clk)
        $fell(rst) |-> ##[0:READY_LIMIT] ready_q)
        else $error("ready never set");
    a_flag_sets: assert property (@(posedge core_clk) disable iff (rst)
        cond.mid_rail_volt |=> flag_q[0])
        else $error("voltage flag not latched");
    a_flag_held_read: assert property (@(posedge core_clk) disable iff (rst)
        (flag_q[2] && st_rd && cond.remote_one_temp) |=> flag_q[2])
        else $error("flag cleared while condition active");
    a_flag_clears: assert property (@(posedge core_clk) disable iff (rst)
        (st_rd && !cond.local_temp) |=> !flag_q[3])
        else $error("flag not cleared on read");
    a_summary_or: assert property (@(posedge core_clk) disable iff (rst)
        (req.rd && hit(req, MCSR_ADDR_STAT1))
        |=> rdata_q[MCSR_ST_SUM] == |$past(status_two))
        else $error("summary bit wrong");
    a_reserved_zero: assert property (@(posedge core_clk) disable iff (rst)
        $past(req.rd) |-> (rdata_q[MCSR_ST_RSVD_A] == 1'b0 || $past(hit(req, MCSR_ADDR_CONFIG))))
        else $error("reserved bit not zero");
    a_status_rsvd: assert property (@(posedge core_clk) disable iff (rst)
        st_rd |=> (!rdata_q[MCSR_ST_RSVD_A] && !rdata_q[MCSR_ST_RSVD_B]))
        else $error("status reserved bit not zero");
    a_cfg_rsvd: assert property (@(posedge core_clk) disable iff (rst)
        (req.rd && hit(req, MCSR_ADDR_CONFIG)) |=> !rdata_q[MCSR_CFG_RSVD])
        else $error("config reserved bit not zero");

    // an unlocked write takes every lockable bit, a locked one takes none
    a_cfg_wr_taken: assert property (@(posedge core_clk) disable iff (rst)
        (cfg_wr && !lock_q) |=> ({go_q, lock_q, spin_q, tmo_q, vsc_q} ==
            $past({req.wdata[MCSR_CFG_GO], req.wdata[MCSR_CFG_LOCK], req.wdata[MCSR_CFG_SPIN],
                   req.wdata[MCSR_CFG_TMO_OFF], req.wdata[MCSR_CFG_VSCALE]})))
        else $error("config write not taken");
    a_locked_wr_quiet: assert property (@(posedge core_clk) disable iff (rst)
        (cfg_wr && lock_q) |=> ({go_q, lock_q, spin_q, tmo_q, vsc_q} ==
            $past({go_q, lock_q, spin_q, tmo_q, vsc_q})))
        else $error("locked write changed a lockable bit");

    // settle counter, ready and reset
    a_ready_count: assert property (@(posedge core_clk) disable iff (rst)
        ready_q |-> (pwr_cnt_q == CNT_W'(PWRUP_CYCLES)))
        else $error("ready set before settle time");
    a_ready_held: assert property (@(posedge core_clk) disable iff (rst)
        ready_q |=> ready_q)
        else $error("ready dropped without reset");
    a_reset_clears: assert property (@(posedge core_clk)
        rst |=> (ctrl == '0 && flag_q == '0 && !ready_q && rdata_q == MCSR_RD_UNMAPPED))
        else $error("reset left state behind");

    // every channel latches, holds between reads and clears only on a quiet read
    for (genvar i = 0; i < MCSR_NFLAGS; i++) begin : g_flag_chk
        a_flag_latch: assert property (@(posedge core_clk) disable iff (rst)
            cond[i] |=> flag_q[i])
            else $error("flag not latched");
        a_flag_quiet_clr: assert property (@(posedge core_clk) disable iff (rst)
            (st_rd && !cond[i]) |=> !flag_q[i])
            else $error("flag kept after quiet read");
        a_flag_hold: assert property (@(posedge core_clk) disable iff (rst)
            (flag_q[i] && !st_rd) |=> flag_q[i])
            else $error("flag dropped without a read");
    end
endmodule

// ===== verification/mcsr_host.sv
module mcsr_host
    import mcsr_pkg::*;
(
    // clock
    input  wire logic core_clk,
    // register port
    output mcsr_req_t req
);
    timeunit 1ns;
    timeprecision 1ps;
    initial req = '0;
    // one-cycle strobe, then an idle cycle so no edge sees two requests
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge core_clk);
        req <= '0;
    endtask
endmodule

// ===== verification/testbench.sv
module testbench
    import mcsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       core_clk   = 1'b0;
    logic       rst        = 1'b1;
    logic [7:0] status_two = 8'h00;
    logic [7:0] rdata_q, cfg, v, h;
    logic [7:0] exp_q[$];
    logic       rd_pend    = 1'b0;
    mcsr_cond_t cond       = '0;
    mcsr_req_t  req;
    mcsr_ctrl_t ctrl;
    int         mismatches = 0;
    int         compares   = 0;

    initial forever #10 core_clk = ~core_clk;

    mcsr_host u_mcsr_host (.core_clk(core_clk), .req(req));
    mcsr_regs #(.PWRUP_CYCLES(4)) u_mcsr_regs (.core_clk(core_clk), .rst(rst), .req(req),
        .rdata_q(rdata_q), .cond(cond), .status_two(status_two), .ctrl(ctrl));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
        compares++;
        if (seen !== want) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    function automatic logic [7:0] ectl(input logic [7:0] c);
        return {2'b00, c[0], c[3], c[5], c[6], c[7], c[1]};
    endfunction

    // summary bit is live, flags sit at 0,2,4,5,6
    function automatic logic [7:0] est(input logic [4:0] c);
        return {|status_two, c[4:2], 1'b0, c[1], 1'b0, c[0]};
    endfunction

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_mcsr_host.access(1'b0, a, 8'h00);
    endtask

    always @(posedge core_clk) rd_pend <= req.rd;
    always @(negedge core_clk) begin
        if (rd_pend) check("read data", rdata_q, exp_q.pop_front());
    end

    initial begin
        #50us;
        mismatches++;
        give_verdict();
    end

    initial begin
        void'($urandom(10));
        repeat (20) @(posedge core_clk);
        @(negedge core_clk) rst = 1'b0;
        rd(8'h40, 8'h00);
        repeat (6) @(negedge core_clk);
        rd(8'h40, 8'h04);
        rd(8'h55, 8'h00);
        for (int i = 0; i < 8; i++) begin
            cfg = 8'($urandom()) & 8'he9;
            u_mcsr_host.access(1'b1, 8'h40, cfg | 8'h10);
            check("ctrl", {2'b00, ctrl}, ectl(cfg));
            rd(8'h40, cfg | 8'h04);
        end
        // limits live outside this block, so go is a plain bit above and only lock comes last
        cfg = 8'hc3;
        u_mcsr_host.access(1'b1, 8'h40, cfg);
        for (int i = 0; i < 6; i++) begin
            v = 8'($urandom());
            u_mcsr_host.access(1'b1, 8'h40, v);
            cfg[3] = v[3];
            check("ctrl locked", {2'b00, ctrl}, ectl(cfg));
            rd(8'h40, cfg | 8'h04);
        end
        u_mcsr_host.access(1'b1, 8'h41, 8'hff);
        rd(8'h41, 8'h00);
        for (int i = 0; i < 6; i++) begin
            v = 8'($urandom());
            h = v & 8'($urandom());
            status_two = (i < 2) ? 8'h00 : 8'($urandom());
            cond = v[4:0];
            repeat (2) @(negedge core_clk);
            cond = h[4:0];
            rd(8'h41, est(v[4:0]));
            rd(8'h41, est(h[4:0]));
            @(negedge core_clk) cond = '0;
            rd(8'h41, est(h[4:0]));
            rd(8'h41, est(5'h00));
        end
        @(negedge core_clk) rst = 1'b1;
        @(negedge core_clk) rst = 1'b0;
        check("ctrl reset", {2'b00, ctrl}, 8'h00);
        rd(8'h40, 8'h00);
        @(negedge core_clk);
        give_verdict();
    end
endmodule
